// *** inc/ictm_map.svh ***
`ifndef ICTM_MAP_SVH
`define ICTM_MAP_SVH

// ==========================================================
// Register numbers on the register port
`define ICTM_MAP_REG_LAST 12'hbff
`define ICTM_CDR_ADDR 12'hc00
`define ICTM_STAT_ADDR 12'hfc0
`define ICTM_MASK_ADDR 12'hfc1
`define ICTM_BUSY_ADDR 12'hfc3

// ==========================================================
// Map table geometry
`define ICTM_SLOTS 1536
`define ICTM_MS_SLOT_TAG 2'h2
`define ICTM_OFS_W 10
`define ICTM_SLOT_V 31
`define ICTM_SLOT_D 30

// ==========================================================
// Channel definition register, bit positions counted from the LSB
`define ICTM_CDR_BVE 12
`define ICTM_CDR_DVE 11
`define ICTM_CDR_BAP 8
`define ICTM_CDR_BDP 7
`define ICTM_CDR_DIS 6
`define ICTM_CDR_MAP_EN 1

// ==========================================================
// Status register constant bits and reset values
`define ICTM_STAT_ONES 16'h000c

`endif

// *** inc/ictm_pkg.sv ***
package ictm_pkg;

    // ==========================================================
    // Transfer sequencer states and channel selector
    typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_DATA} ictm_state_t;
    typedef enum logic {CH_MS, CH_BURST} ictm_chan_t;

    // ==========================================================
    // Whole state of the top module
    typedef struct packed {
        logic [2:0] lclk;
        logic [7:0] ms_s1;
        logic [7:0] ms_s2;
        logic [7:0] br_s1;
        logic [7:0] br_s2;
        logic [19:0] adr_s1;
        logic [19:0] adr_s2;
        logic [3:0] ctl_s1;
        logic [3:0] ctl_s2;
        logic [15:0] dat_s1;
        logic [15:0] dat_s2;
        ictm_state_t state;
        ictm_chan_t chan;
        logic [7:0] gnt;
        logic [19:0] xaddr;
        logic dir;
        logic mapload;
        logic logical;
        logic mem_we;
        logic mem_re;
        logic [19:0] mem_addr;
        logic [15:0] mem_wdata;
        logic rd_pending;
        logic zero_fill;
        logic [15:0] dev_rdata;
        logic bve;
        logic dve;
        logic bap;
        logic bdp;
        logic dis;
        logic map_en;
        logic [3:0] def_chan;
        logic [15:0] chmask;
        logic [1:0] rd_sel;
        logic [15:0] reg_rdata;
        logic ms_busy;
        logic br_busy;
        logic io_rst;
    } ictm_top_st_t;

    // ==========================================================
    // Read registers of the map table
    typedef struct packed {
        logic [31:0] a_rdata;
        logic [31:0] b_rdata;
    } ictm_ram_st_t;

endpackage

// *** rtl/ictm_arb.sv ***
// ==========================================================
// Fixed priority picker: the lowest index wins
module ictm_arb (
    // Requests and one-hot grant
    input wire logic [7:0] req,
    output logic [7:0] gnt,
    output logic any
);

    // Isolate the lowest set bit
    always_comb begin
        gnt = req & (~req + 8'h01);
        any = |req;
    end

endmodule // ictm_arb

// *** rtl/ictm_map_ram.sv ***
`include "ictm_map.svh"

// ==========================================================
// Map table: one 32-bit slot per entry, half-slot write enables
module ictm_map_ram (
    // Clock
    input wire logic clk,
    // Software port
    input wire logic [10:0] a_addr,
    input wire logic [1:0] a_we,
    input wire logic [31:0] a_wdata,
    output logic [31:0] a_rdata,
    // Transfer port
    input wire logic [10:0] b_addr,
    input wire logic [1:0] b_we,
    input wire logic [31:0] b_wdata,
    output logic [31:0] b_rdata
);

    logic [31:0] mem [0:`ICTM_SLOTS-1];
    ictm_pkg::ictm_ram_st_t r;
    ictm_pkg::ictm_ram_st_t n;

    // Registered reads, one cycle latency
    always_comb begin
        n = r;
        n.a_rdata = mem[a_addr];
        n.b_rdata = mem[b_addr];
    end

    always_ff @(posedge clk) begin
        r <= n;
    end

    // Half-slot writes; the transfer port is applied last
    always_ff @(posedge clk) begin
        if (a_we[1]) begin
            mem[a_addr][31:16] <= a_wdata[31:16];
        end
        if (a_we[0]) begin
            mem[a_addr][15:0] <= a_wdata[15:0];
        end
        if (b_we[1]) begin
            mem[b_addr][31:16] <= b_wdata[31:16];
        end
        if (b_we[0]) begin
            mem[b_addr][15:0] <= b_wdata[15:0];
        end
    end

    assign a_rdata = r.a_rdata;
    assign b_rdata = r.b_rdata;

endmodule // ictm_map_ram

// *** rtl/ictm_top.sv ***
// Behaviour
// - Medium-speed grant goes to the nearest requester.
// - Burst grant goes to the highest-priority requester.
// - Reset selects channel 0; I/O reset keeps the default.
// - Read moves device data to memory; write the reverse.
// - Acknowledge only the priority holder on an idle channel.
// - Memory is mapped in two-kilobyte protected pages.
// - Mapped: physical page joined with ten low address bits.
// - Unmapped: word address goes to memory unchanged.
// - Map-load transfers write the map table, not memory.
// - I/O reset resets devices, clears definition bits 0,3,4,7,8,9,14.
// - Register port loads half a slot; block load whole slots.
// - Busy during map load or read; no Done, no interrupt.
// - Slot is an even plus odd register; 512 and 1024 slots.
// - Medium-speed mapping only while its enable bit is one.
// - Burst mapping chosen per sequence by the device.
// - Medium-speed channel: 16 maps of 32 slots, indexed by address.
// - Burst address is 20 bits, logical or physical.
// - Burst logical page is the upper ten address bits.
// - Validity bit zero permits access, one denies it.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`include "ictm_map.svh"

module ictm_top (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Register port
    input wire logic [11:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    // Processor instructions
    input wire logic CHANNEL_SELECT_INSTR,
    input wire logic [3:0] CHANNEL_SELECT_NUM,
    input wire logic IO_RESET_INSTR,
    input wire logic BLOCK_MAP_LOAD_INSTR,
    input wire logic [10:0] BLOCK_MAP_SLOT,
    input wire logic [31:0] BLOCK_MAP_DATA,
    output logic IO_RESET_OUT,
    output logic [3:0] DEFAULT_CHAN,
    output logic MS_MAP_BUSY,
    output logic BURST_MAP_BUSY,
    // Device bus pins
    input wire logic XFER_CLK,
    input wire logic [7:0] MS_REQ,
    input wire logic [7:0] BURST_REQ,
    input wire logic [19:0] DEV_ADDR,
    input wire logic DEV_DIR,
    input wire logic DEV_MAP_LOAD,
    input wire logic DEV_LOGICAL,
    input wire logic DEV_LAST,
    input wire logic [15:0] DEV_WDATA,
    output logic [7:0] MS_ACK,
    output logic [7:0] BURST_ACK,
    output logic [15:0] DEV_RDATA,
    // Memory port
    output logic MEM_WE,
    output logic MEM_RE,
    output logic [19:0] MEM_ADDR,
    output logic [15:0] MEM_WDATA,
    input wire logic [15:0] MEM_RDATA
);

    ictm_pkg::ictm_top_st_t r;
    ictm_pkg::ictm_top_st_t n;

    logic [7:0] ms_gnt;
    logic [7:0] br_gnt;
    logic ms_any;
    logic br_any;
    logic link_edge;
    logic is_map_reg;
    logic [10:0] reg_slot;
    logic [1:0] a_we;
    logic [10:0] a_addr;
    logic [31:0] a_wdata;
    logic [31:0] a_rdata;
    logic [10:0] look_slot;
    logic [10:0] load_slot;
    logic load_low;
    logic [10:0] b_addr;
    logic [1:0] b_we;
    logic [31:0] b_rdata;
    logic mapped;
    logic [19:0] phys;
    logic [15:0] cdr_val;
    logic [15:0] stat_val;
    logic ice;

    // ==========================================================
    // Requester arbitration, one picker per channel
    ictm_arb u_ms_arb (
        .req(r.ms_s2),
        .gnt(ms_gnt),
        .any(ms_any)
    );

    ictm_arb u_br_arb (
        .req(r.br_s2),
        .gnt(br_gnt),
        .any(br_any)
    );

    // ==========================================================
    // Map table decode
    // Register number to slot
    always_comb begin
        is_map_reg = REG_ADDR <= `ICTM_MAP_REG_LAST;
        reg_slot = REG_ADDR[11] ? {`ICTM_MS_SLOT_TAG, REG_ADDR[9:1]}
                                : {1'b0, REG_ADDR[10:1]};
    end

    // Software port
    always_comb begin
        if (BLOCK_MAP_LOAD_INSTR) begin
            a_addr = BLOCK_MAP_SLOT;
            a_we = 2'h3;
            a_wdata = BLOCK_MAP_DATA;
        end else begin
            a_addr = reg_slot;
            a_we = (REG_WR && is_map_reg) ? {~REG_ADDR[0], REG_ADDR[0]} : 2'h0;
            a_wdata = {REG_WDATA, REG_WDATA};
        end
    end

    // Transfer port
    always_comb begin
        link_edge = r.lclk[1] & ~r.lclk[2];
        look_slot = (r.chan == ictm_pkg::CH_BURST) ? {1'b0, r.xaddr[19:10]}
                                                   : {`ICTM_MS_SLOT_TAG, r.xaddr[18:10]};
        load_slot = (r.chan == ictm_pkg::CH_BURST) ? {1'b0, r.xaddr[10:1]}
                                                   : {`ICTM_MS_SLOT_TAG, r.xaddr[8:0]};
        load_low = (r.chan == ictm_pkg::CH_BURST) ? r.xaddr[0] : r.xaddr[15];
        b_addr = r.mapload ? load_slot : look_slot;
        b_we = 2'h0;
        if (link_edge && r.state == ictm_pkg::ST_DATA && r.mapload) begin
            b_we = {~load_low, load_low};
        end
        mapped = (r.chan == ictm_pkg::CH_BURST) ? r.logical : r.map_en;
        phys = mapped ? {b_rdata[9:0], r.xaddr[`ICTM_OFS_W-1:0]} : r.xaddr;
    end

    ictm_map_ram u_map (
        .clk(REF_CLK),
        .a_addr(a_addr),
        .a_we(a_we),
        .a_wdata(a_wdata),
        .a_rdata(a_rdata),
        .b_addr(b_addr),
        .b_we(b_we),
        .b_wdata({r.dat_s2, r.dat_s2}),
        .b_rdata(b_rdata)
    );

    // ==========================================================
    // Readable register images
    always_comb begin
        ice = r.bve | r.dve | r.bap | r.bdp;
        cdr_val = {ice, 2'h0, r.bve, r.dve,
                   r.state != ictm_pkg::ST_IDLE && r.chan == ictm_pkg::CH_MS,
                   r.state != ictm_pkg::ST_IDLE && r.chan == ictm_pkg::CH_BURST,
                   r.bap, r.bdp, r.dis, r.def_chan, r.map_en, 1'b1};
        stat_val = `ICTM_STAT_ONES | {ice, 13'h0000, r.chmask[r.def_chan], 1'b0};
    end

    // ==========================================================
    // Next state
    always_comb begin
        n = r;
        // Two-stage synchronisers for every pin from the device bus
        n.lclk = {r.lclk[1:0], XFER_CLK};
        n.ms_s1 = MS_REQ;
        n.ms_s2 = r.ms_s1;
        n.br_s1 = BURST_REQ;
        n.br_s2 = r.br_s1;
        n.adr_s1 = DEV_ADDR;
        n.adr_s2 = r.adr_s1;
        n.ctl_s1 = {DEV_LAST, DEV_LOGICAL, DEV_MAP_LOAD, DEV_DIR};
        n.ctl_s2 = r.ctl_s1;
        n.dat_s1 = DEV_WDATA;
        n.dat_s2 = r.dat_s1;
        n.mem_we = 1'b0;
        n.mem_re = 1'b0;
        n.rd_pending = 1'b0;
        n.io_rst = 1'b0;

        // Memory read data is taken at the end of the strobe's own cycle
        if (r.rd_pending) begin
            n.dev_rdata = MEM_RDATA;
        end

        // Register writes, the channel I/O instruction path
        if (REG_WR) begin
            case (REG_ADDR)
                `ICTM_CDR_ADDR: begin
                    n.bve = r.bve ^ REG_WDATA[`ICTM_CDR_BVE];
                    n.dve = r.dve ^ REG_WDATA[`ICTM_CDR_DVE];
                    n.bap = r.bap ^ REG_WDATA[`ICTM_CDR_BAP];
                    n.bdp = r.bdp ^ REG_WDATA[`ICTM_CDR_BDP];
                    n.dis = REG_WDATA[`ICTM_CDR_DIS];
                    n.map_en = REG_WDATA[`ICTM_CDR_MAP_EN];
                end
                `ICTM_MASK_ADDR: begin
                    n.chmask = REG_WDATA;
                end
                default: begin
                end
            endcase
        end

        // Register reads, answered in the next cycle
        if (REG_RD) begin
            n.rd_sel = is_map_reg ? {1'b1, REG_ADDR[0]} : 2'h0;
            case (REG_ADDR)
                `ICTM_CDR_ADDR: n.reg_rdata = cdr_val;
                `ICTM_STAT_ADDR: n.reg_rdata = stat_val;
                `ICTM_BUSY_ADDR: n.reg_rdata = {14'h0000, r.br_busy, r.ms_busy};
                default: n.reg_rdata = 16'h0000;
            endcase
        end

        // Map busy flags
        n.ms_busy = (r.state != ictm_pkg::ST_IDLE && r.chan == ictm_pkg::CH_MS && r.mapload)
                    || ((REG_WR || REG_RD) && is_map_reg && REG_ADDR[11]);
        n.br_busy = (r.state != ictm_pkg::ST_IDLE && r.chan == ictm_pkg::CH_BURST && r.mapload)
                    || ((REG_WR || REG_RD) && is_map_reg && !REG_ADDR[11])
                    || BLOCK_MAP_LOAD_INSTR;

        // Default channel follows only the select instruction
        if (CHANNEL_SELECT_INSTR) begin
            n.def_chan = CHANNEL_SELECT_NUM;
        end

        // Transfer sequencer, stepped by rising edges of the link clock
        case (r.state)
            ictm_pkg::ST_IDLE: begin
                if (link_edge && br_any) begin
                    n.chan = ictm_pkg::CH_BURST;
                    n.gnt = br_gnt;
                    n.state = ictm_pkg::ST_ACK;
                end else if (link_edge && ms_any) begin
                    n.chan = ictm_pkg::CH_MS;
                    n.gnt = ms_gnt;
                    n.state = ictm_pkg::ST_ACK;
                end
            end
            ictm_pkg::ST_ACK: begin
                if (link_edge) begin
                    n.xaddr = r.adr_s2;
                    n.dir = r.ctl_s2[0];
                    n.mapload = r.ctl_s2[1];
                    n.logical = r.ctl_s2[2];
                    n.state = ictm_pkg::ST_DATA;
                end
            end
            ictm_pkg::ST_DATA: begin
                if (link_edge) begin
                    if (!r.mapload) begin
                        if (mapped && b_rdata[`ICTM_SLOT_V]) begin
                            // Page denied: no memory cycle, flag the error
                            if (r.chan == ictm_pkg::CH_BURST) begin
                                n.bve = 1'b1;
                            end else begin
                                n.dve = 1'b1;
                            end
                        end else if (!r.dir) begin
                            n.mem_we = 1'b1;
                            n.mem_addr = phys;
                            n.mem_wdata = (mapped && b_rdata[`ICTM_SLOT_D]) ? 16'h0000
                                                                            : r.dat_s2;
                        end else if (mapped && b_rdata[`ICTM_SLOT_D]) begin
                            n.dev_rdata = 16'h0000;
                        end else begin
                            n.mem_re = 1'b1;
                            n.mem_addr = phys;
                            n.rd_pending = 1'b1;
                        end
                    end
                    // Step to the next word, crossing pages through the map
                    n.xaddr = r.xaddr + 20'h00001;
                    if (r.chan == ictm_pkg::CH_MS || r.ctl_s2[3]) begin
                        n.gnt = 8'h00;
                        n.state = ictm_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                n.state = ictm_pkg::ST_IDLE;
                n.gnt = 8'h00;
            end
        endcase

        // I/O reset
        if (IO_RESET_INSTR) begin
            n.io_rst = 1'b1;
            n.bve = 1'b0;
            n.dve = 1'b0;
            n.bap = 1'b0;
            n.bdp = 1'b0;
            n.dis = 1'b0;
            n.map_en = 1'b0;
            n.state = ictm_pkg::ST_IDLE;
            n.gnt = 8'h00;
            n.mem_we = 1'b0;
            n.mem_re = 1'b0;
        end
    end

    // ==========================================================
    // State register, synchronous reset
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        case (r.rd_sel)
            2'h2: REG_RDATA = a_rdata[31:16];
            2'h3: REG_RDATA = a_rdata[15:0];
            default: REG_RDATA = r.reg_rdata;
        endcase
        IO_RESET_OUT = r.io_rst;
        DEFAULT_CHAN = r.def_chan;
        MS_MAP_BUSY = r.ms_busy;
        BURST_MAP_BUSY = r.br_busy;
        MS_ACK = (r.chan == ictm_pkg::CH_MS) ? r.gnt : 8'h00;
        BURST_ACK = (r.chan == ictm_pkg::CH_BURST) ? r.gnt : 8'h00;
        DEV_RDATA = r.dev_rdata;
        MEM_WE = r.mem_we;
        MEM_RE = r.mem_re;
        MEM_ADDR = r.mem_addr;
        MEM_WDATA = r.mem_wdata;
    end

endmodule // ictm_top

// *** verif/ictm_top_sva.sv ***
// ==========================================================
// Port checker
module ictm_top_sva (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Instructions
    input wire logic CHANNEL_SELECT_INSTR,
    input wire logic [3:0] CHANNEL_SELECT_NUM,
    input wire logic IO_RESET_INSTR,
    input wire logic IO_RESET_OUT,
    input wire logic [3:0] DEFAULT_CHAN,
    // Link and memory
    input wire logic [7:0] MS_REQ,
    input wire logic [7:0] BURST_REQ,
    input wire logic [7:0] MS_ACK,
    input wire logic [7:0] BURST_ACK,
    input wire logic MEM_WE,
    input wire logic MEM_RE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);

    // ==========================================================
    // Grant steps
    sequence ms_won;
        $rose(|MS_ACK);
    endsequence
    sequence br_won;
        $rose(|BURST_ACK);
    endsequence

    // Grants
    ack_one_hot_a: assert property ($onehot0({MS_ACK, BURST_ACK}))
        else $error("two grants at once");
    ms_nearest_a: assert property (ms_won |-> ((MS_ACK & MS_REQ) == MS_ACK)
        && (((MS_ACK - 8'h01) & MS_REQ) == 8'h00)) else $error("wrong near grant");
    br_highest_a: assert property (br_won |-> ((BURST_ACK & BURST_REQ) == BURST_ACK)
        && (((BURST_ACK - 8'h01) & BURST_REQ) == 8'h00)) else $error("wrong burst grant");
    ms_one_word_a: assert property (ms_won |-> ##[1:40] (MS_ACK == 8'h00))
        else $error("near grant not ended");
    br_ack_hold_a: assert property ((|BURST_ACK) |=>
        (BURST_ACK == $past(BURST_ACK)) || (BURST_ACK == 8'h00)) else $error("grant moved");
    mem_in_seq_a: assert property ((MEM_WE || MEM_RE) |->
        $past(|{MS_ACK, BURST_ACK}) || $past(|{MS_ACK, BURST_ACK}, 2)) else $error("stray strobe");
    mem_one_dir_a: assert property ((MEM_WE || MEM_RE) |-> !(MEM_WE && MEM_RE)
        ##1 !(MEM_WE || MEM_RE)) else $error("bad memory strobe");

    // Default channel
    chan_select_a: assert property (CHANNEL_SELECT_INSTR |=>
        DEFAULT_CHAN == $past(CHANNEL_SELECT_NUM)) else $error("channel not taken");
    chan_keep_a: assert property (IO_RESET_INSTR && !CHANNEL_SELECT_INSTR |=>
        $stable(DEFAULT_CHAN)) else $error("channel changed by reset");
    chan_reset_a: assert property ($fell(RST) |-> DEFAULT_CHAN == 4'h0)
        else $error("channel not zero");
    io_pulse_a: assert property (IO_RESET_INSTR |=> IO_RESET_OUT ##1 !IO_RESET_OUT)
        else $error("reset pulse wrong");
endmodule // ictm_top_sva

// *** verif/ictm_dev_model.sv ***
// ==========================================================
// Device controllers on the far side of the link
module ictm_dev_model (
    // Pacing clock
    input wire logic clk,
    // Grants
    input wire logic [7:0] ms_ack,
    input wire logic [7:0] br_ack,
    // Link pins
    output logic xfer_clk,
    output logic [7:0] ms_req,
    output logic [7:0] br_req,
    output logic [19:0] dev_addr,
    output logic dev_dir,
    output logic dev_map_load,
    output logic dev_logical,
    output logic dev_last,
    output logic [15:0] dev_wdata,
    // Grant seen last
    output logic [15:0] ack_seen
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle link
    initial begin
        xfer_clk = 1'b0;
        ms_req = 8'h00;
        br_req = 8'h00;
        dev_addr = 20'h00000;
        dev_dir = 1'b0;
        dev_map_load = 1'b0;
        dev_logical = 1'b0;
        dev_last = 1'b0;
        dev_wdata = 16'h0000;
        ack_seen = 16'h0000;
    end

    // Half a link period, four system clocks
    task automatic half(input logic hi);
        xfer_clk <= hi;
        repeat (4) @(posedge clk);
    endtask

    // One sequence of n words
    task automatic xfer(input logic [7:0] msr, input logic [7:0] brr, input logic [19:0] a,
        input logic dir, input logic ml, input logic lg, input int n, input logic [15:0] d0);
        int k;
        ms_req <= msr;
        br_req <= brr;
        dev_addr <= a;
        dev_dir <= dir;
        dev_map_load <= ml;
        dev_logical <= lg;
        k = 0;
        ack_seen = 16'h0000;
        while (ack_seen == 16'h0000 && k < 16) begin
            half(1'b1);
            half(1'b0);
            ack_seen = {ms_ack, br_ack};
            k++;
        end
        // Set-up edge
        half(1'b1);
        ms_req <= 8'h00;
        br_req <= 8'h00;
        dev_addr <= ~a;
        dev_dir <= ~dir;
        dev_map_load <= ~ml;
        dev_logical <= ~lg;
        dev_wdata <= d0;
        dev_last <= (n == 1);
        half(1'b0);
        // One word per edge
        for (k = 1; k <= n; k++) begin
            half(1'b1);
            dev_wdata <= (k < n) ? d0 + k[15:0] : ~dev_wdata;
            dev_last <= (k == n - 1);
            half(1'b0);
        end
        repeat (8) @(posedge clk);
    endtask
endmodule // ictm_dev_model

// *** verif/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Signals
    logic REF_CLK;
    logic RST = 1'b1;
    logic [11:0] REG_ADDR = 12'h000;
    logic [15:0] REG_WDATA = 16'h0000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic CHANNEL_SELECT_INSTR = 1'b0;
    logic IO_RESET_INSTR = 1'b0;
    logic BLOCK_MAP_LOAD_INSTR = 1'b0;
    logic [3:0] CHANNEL_SELECT_NUM = 4'h0;
    logic [10:0] BLOCK_MAP_SLOT = 11'h000;
    logic [31:0] BLOCK_MAP_DATA = 32'h0000_0000;
    logic [15:0] MEM_RDATA;
    logic [15:0] REG_RDATA, DEV_WDATA, DEV_RDATA, MEM_WDATA, ack_seen;
    logic [3:0] DEFAULT_CHAN;
    logic IO_RESET_OUT, MS_MAP_BUSY, BURST_MAP_BUSY, MEM_WE, MEM_RE;
    logic XFER_CLK, DEV_DIR, DEV_MAP_LOAD, DEV_LOGICAL, DEV_LAST;
    logic [7:0] MS_REQ, BURST_REQ, MS_ACK, BURST_ACK;
    logic [19:0] DEV_ADDR, MEM_ADDR;
    logic [35:0] wq[$];
    logic [15:0] rq[$];
    logic [1:0] re_d = 2'h0;
    int err_total = 0;
    int total_checks = 0;

    ictm_top i_ictm_top (.REF_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
        .CHANNEL_SELECT_INSTR, .CHANNEL_SELECT_NUM, .IO_RESET_INSTR, .BLOCK_MAP_LOAD_INSTR,
        .BLOCK_MAP_SLOT, .BLOCK_MAP_DATA, .IO_RESET_OUT, .DEFAULT_CHAN, .MS_MAP_BUSY,
        .BURST_MAP_BUSY, .XFER_CLK, .MS_REQ, .BURST_REQ, .DEV_ADDR, .DEV_DIR, .DEV_MAP_LOAD,
        .DEV_LOGICAL, .DEV_LAST, .DEV_WDATA, .MS_ACK, .BURST_ACK, .DEV_RDATA, .MEM_WE,
        .MEM_RE, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA);
    ictm_dev_model i_ictm_dev_model (.clk(REF_CLK), .ms_ack(MS_ACK), .br_ack(BURST_ACK),
        .xfer_clk(XFER_CLK), .ms_req(MS_REQ), .br_req(BURST_REQ), .dev_addr(DEV_ADDR),
        .dev_dir(DEV_DIR), .dev_map_load(DEV_MAP_LOAD), .dev_logical(DEV_LOGICAL),
        .dev_last(DEV_LAST), .dev_wdata(DEV_WDATA), .ack_seen(ack_seen));

    // Clock, 25 ns period
    initial begin
        REF_CLK = 1'b0;
        forever #12.5 REF_CLK = ~REF_CLK;
    end

    // Memory model: a read answers in the strobe's own cycle
    assign MEM_RDATA = MEM_RE ? MEM_ADDR[15:0] ^ 16'h5a5a : 16'hffff;
    always @(posedge REF_CLK) begin
        if (MEM_WE) wq.push_back({MEM_ADDR, MEM_WDATA});
        if (re_d[1]) rq.push_back(DEV_RDATA);
        re_d <= {re_d[0], MEM_RE};
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
        @(posedge REF_CLK);
    endtask

    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1 chk(REG_RDATA, e);
        @(posedge REF_CLK);
    endtask

    task automatic ins(input logic cs, input logic io);
        CHANNEL_SELECT_INSTR <= cs;
        IO_RESET_INSTR <= io;
        @(posedge REF_CLK);
        CHANNEL_SELECT_INSTR <= 1'b0;
        IO_RESET_INSTR <= 1'b0;
        @(posedge REF_CLK);
    endtask

    task automatic bml(input logic [10:0] s, input logic [31:0] d);
        BLOCK_MAP_SLOT <= s;
        BLOCK_MAP_DATA <= d;
        BLOCK_MAP_LOAD_INSTR <= 1'b1;
        @(posedge REF_CLK);
        BLOCK_MAP_LOAD_INSTR <= 1'b0;
        @(posedge REF_CLK);
    endtask

    task automatic go(input logic [7:0] msr, input logic [7:0] brr, input logic [19:0] a,
        input logic dir, input logic ml, input logic lg, input int n, input logic [15:0] d0,
        input logic [15:0] ack);
        wq.delete();
        rq.delete();
        i_ictm_dev_model.xfer(msr, brr, a, dir, ml, lg, n, d0);
        chk(ack_seen, ack);
    endtask

    task automatic xchk(input int sz, input int n, input logic [19:0] pa, input logic [15:0] d0);
        chk(wq.size(), sz);
        for (int i = 0; i < n; i++) begin
            chk(wq[i], {pa + i[19:0], d0 + i[15:0]});
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        err_total++;
        stop_test();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        chk(DEFAULT_CHAN, 4'h0);
        rd(12'hc00, 16'h0001);
        rd(12'hfc0, 16'h000c);
        rd(12'hfc3, 16'h0000);
        wr(12'hd00, 16'hffff);
        rd(12'hd00, 16'h0000);
        CHANNEL_SELECT_NUM <= 4'h5;
        ins(1'b1, 1'b0);
        chk(DEFAULT_CHAN, 4'h5);
        wr(12'hc00, 16'h0042);
        rd(12'hc00, 16'h0057);
        ins(1'b0, 1'b1);
        chk(DEFAULT_CHAN, 4'h5);
        rd(12'hc00, 16'h0015);
        // Map slots
        wr(12'h004, 16'h0000);
        wr(12'h005, 16'h0123);
        bml(11'h003, 32'h0000_0077);
        bml(11'h004, 32'h8000_0000);
        rd(12'h005, 16'h0123);
        rd(12'h007, 16'h0077);
        rd(12'h008, 16'h8000);
        // Burst transfers
        go(8'h00, 8'h01, 20'h12345, 1'b0, 1'b0, 1'b0, 3, 16'h1000, 16'h0001);
        xchk(3, 3, 20'h12345, 16'h1000);
        go(8'h00, 8'h02, 20'h00bfe, 1'b0, 1'b0, 1'b1, 3, 16'h2000, 16'h0002);
        xchk(3, 2, {10'h123, 10'h3fe}, 16'h2000);
        chk(wq[2], {10'h077, 10'h000, 16'h2002});
        go(8'h00, 8'h60, 20'h00040, 1'b1, 1'b0, 1'b0, 2, 16'h0000, 16'h0020);
        chk(wq.size(), 0);
        chk(rq.size(), 2);
        chk(rq[0], 16'h5a1a);
        chk(rq[1], 16'h5a1b);
        go(8'h00, 8'h01, 20'h01000, 1'b0, 1'b0, 1'b1, 1, 16'h3000, 16'h0001);
        chk(wq.size(), 0);
        rd(12'hc00, 16'h9015);
        wr(12'hc00, 16'h1000);
        rd(12'hc00, 16'h0015);
        // Medium-speed channel
        go(8'h0c, 8'h00, 20'h01411, 1'b0, 1'b0, 1'b0, 1, 16'h4000, 16'h0400);
        xchk(1, 1, 20'h01411, 16'h4000);
        wr(12'hc00, 16'h0002);
        wr(12'h80a, 16'h0000);
        go(8'h01, 8'h00, 20'h08005, 1'b0, 1'b1, 1'b0, 1, 16'h0155, 16'h0100);
        chk(wq.size(), 0);
        rd(12'h80b, 16'h0155);
        go(8'h01, 8'h00, 20'h01411, 1'b0, 1'b0, 1'b0, 1, 16'h5000, 16'h0100);
        xchk(1, 1, {10'h155, 10'h011}, 16'h5000);
        // Burst map load
        go(8'h00, 8'h01, 20'h0000c, 1'b0, 1'b1, 1'b0, 2, 16'h0000, 16'h0001);
        chk(wq.size(), 0);
        rd(12'h00c, 16'h0000);
        rd(12'h00d, 16'h0001);
        stop_test();
    end
endmodule // tb

bind ictm_top ictm_top_sva i_ictm_top_sva (.REF_CLK, .RST, .CHANNEL_SELECT_INSTR,
    .CHANNEL_SELECT_NUM, .IO_RESET_INSTR, .IO_RESET_OUT, .DEFAULT_CHAN, .MS_REQ, .BURST_REQ,
    .MS_ACK, .BURST_ACK, .MEM_WE, .MEM_RE);
